// >>> rtl/msg_mem.v
// small message store for outgoing packets
module msg_mem (
	input  wire       clk_sys,
	input  wire       we,
	input  wire [2:0] waddr,
	input  wire [7:0] wdata,
	input  wire [2:0] raddr,
	output reg  [7:0] rdata
);
	reg [7:0] mem [0:7];

	always @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// >>> rtl/touch_host_serial_port.v
// host serial slave port: two-wire bus and spi, strap selected
`include "touch_port_map.vh"
module touch_host_serial_port (
	input  wire       clk_sys,
	input  wire       rst_n,
	input  wire       interface_select_strap,
	input  wire       scl_in,
	output reg        scl_out,
	output reg        scl_oe,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire       ss_n,
	output reg        sdo_out,
	output reg        sdo_oe,
	output reg        host_data_irq,
	input  wire       sleep_enter,
	input  wire       pkt_wr,
	input  wire [7:0] pkt_data,
	input  wire       pkt_commit,
	input  wire       stall_req,
	output reg        cmd_valid,
	output reg  [7:0] cmd_byte,
	output reg        cmd_frame_end
);
	localparam S_IDLE = 6'h01;
	localparam S_ADDR = 6'h02;
	localparam S_AACK = 6'h04;
	localparam S_WR   = 6'h08;
	localparam S_RD   = 6'h10;
	localparam S_RACK = 6'h20;

	// two-flop synchronisers; stage one is read only by stage two
	reg [1:0] scl_s_r, sda_s_r, ss_s_r, strap_s_r;
	reg       scl_d_r, sda_d_r;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			scl_s_r   <= 2'h3;
			sda_s_r   <= 2'h3;
			ss_s_r    <= 2'h3;
			strap_s_r <= 2'h0;
			scl_d_r   <= 1'b1;
			sda_d_r   <= 1'b1;
		end else begin
			scl_s_r   <= {scl_s_r[0], scl_in};
			sda_s_r   <= {sda_s_r[0], sda_in};
			ss_s_r    <= {ss_s_r[0], ss_n};
			strap_s_r <= {strap_s_r[0], interface_select_strap};
			scl_d_r   <= scl_s_r[1];
			sda_d_r   <= sda_s_r[1];
		end
	end
	wire scl_q = scl_s_r[1];
	wire sda_q = sda_s_r[1];
	wire scl_rise = scl_q & ~scl_d_r;
	wire scl_fall = ~scl_q & scl_d_r;
	// sda moving while scl high marks start or stop
	wire start_ev = scl_q & scl_d_r & ~sda_q & sda_d_r;
	wire stop_ev  = scl_q & scl_d_r & sda_q & ~sda_d_r;

	// strap caught once the synchroniser holds the pin, not its reset value
	reg       spi_mode_r;
	reg [1:0] strap_cnt_r;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			spi_mode_r  <= 1'b0;
			strap_cnt_r <= 2'h0;
		end else if (strap_cnt_r != 2'h3) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == 2'h2) begin
				spi_mode_r <= strap_s_r[1];
			end
		end
	end

	// outgoing packet bookkeeping
	reg [2:0] wr_ptr_r, rd_ptr_r, len_r;
	reg       pend_r;
	wire [7:0] mem_rdata;
	msg_mem u_mem (
		.clk_sys (clk_sys),
		.we      (pkt_wr),
		.waddr   (wr_ptr_r),
		.wdata   (pkt_data),
		.raddr   (rd_ptr_r),
		.rdata   (mem_rdata)
	);

	reg [5:0] st_r;
	reg [3:0] bit_r;
	reg [7:0] sh_r;
	reg       rd_dir_r;
	reg       first_out_r;
	reg       byte_out_p;
	reg [3:0] str_r;
	reg       spi_sel_d_r;
	reg [7:0] rx_r;
	reg [1:0] ld_r;

	wire spi_sel = spi_mode_r & ~ss_s_r[1];
	// empty store reads back the filler byte
	wire [7:0] out_byte = pend_r ? mem_rdata : `FILLER_BYTE;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_r <= 3'h0;
			len_r    <= 3'h0;
			pend_r   <= 1'b0;
		end else begin
			if (sleep_enter) begin
				pend_r   <= 1'b0;
				wr_ptr_r <= 3'h0;
				len_r    <= 3'h0;
			end else begin
				if (pkt_wr) begin
					wr_ptr_r <= wr_ptr_r + 3'h1;
				end
				if (pkt_commit) begin
					pend_r   <= 1'b1;
					len_r    <= wr_ptr_r;
					wr_ptr_r <= 3'h0;
				end else if (pend_r && byte_out_p &&
					rd_ptr_r == len_r) begin
					pend_r <= 1'b0;
				end
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r          <= S_IDLE;
			bit_r         <= 4'h0;
			sh_r          <= 8'h00;
			rd_dir_r      <= 1'b0;
			rd_ptr_r      <= 3'h0;
			byte_out_p    <= 1'b0;
			rx_r          <= 8'h00;
			ld_r          <= 2'h0;
			sda_out       <= 1'b0;
			sda_oe        <= 1'b0;
			scl_out       <= 1'b0;
			scl_oe        <= 1'b0;
			str_r         <= 4'h0;
			cmd_valid     <= 1'b0;
			cmd_byte      <= 8'h00;
			cmd_frame_end <= 1'b0;
			spi_sel_d_r   <= 1'b0;
		end else begin
			byte_out_p    <= 1'b0;
			cmd_valid     <= 1'b0;
			cmd_frame_end <= 1'b0;
			sda_out       <= 1'b0;
			spi_sel_d_r   <= spi_sel;
			if (sleep_enter || pkt_commit) begin
				rd_ptr_r <= 3'h0;
			end
			if (spi_mode_r) begin
				st_r   <= S_IDLE;
				sda_oe <= 1'b0;
				scl_oe <= 1'b0;
				ld_r   <= {1'b0, ld_r[1]};
				if (ld_r[0]) begin
					sh_r <= out_byte;
				end
				if (!spi_sel) begin
					bit_r <= 4'h0;
					if (spi_sel_d_r) begin
						cmd_frame_end <= 1'b1;
					end
				end else if (bit_r == 4'h0 && !spi_sel_d_r) begin
					// preload first byte as soon as selected
					sh_r  <= out_byte;
					bit_r <= 4'h8;
				end else if (scl_rise) begin
					rx_r  <= {rx_r[6:0], sda_q};
					bit_r <= bit_r - 4'h1;
				end else if (scl_fall && bit_r == 4'h0) begin
					// byte done; next out byte once memory read settles
					cmd_valid <= 1'b1;
					cmd_byte  <= rx_r;
					bit_r     <= 4'h8;
					ld_r      <= 2'h2;
					if (pend_r) begin
						byte_out_p <= 1'b1;
						rd_ptr_r   <= rd_ptr_r + 3'h1;
					end else begin
						rd_ptr_r <= 3'h0;
					end
				end else if (scl_fall && bit_r != 4'h8) begin
					sh_r <= {sh_r[6:0], 1'b0};
				end
			end else if (start_ev) begin
				st_r   <= S_ADDR;
				bit_r  <= 4'h0;
				sda_oe <= 1'b0;
				scl_oe <= 1'b0;
			end else if (stop_ev) begin
				if (st_r != S_IDLE && !rd_dir_r) begin
					cmd_frame_end <= 1'b1;
				end
				st_r   <= S_IDLE;
				sda_oe <= 1'b0;
				scl_oe <= 1'b0;
			end else begin
				// stretch: hold scl low after the ack, while busy
				if (scl_oe && str_r != 4'h0) begin
					str_r <= str_r - 4'h1;
				end else if (scl_oe && !stall_req) begin
					scl_oe <= 1'b0;
				end
				case (st_r)
				S_IDLE: begin
					sda_oe <= 1'b0;
				end
				S_ADDR: if (scl_rise) begin
					sh_r  <= {sh_r[6:0], sda_q};
					bit_r <= bit_r + 4'h1;
				end else if (scl_fall && bit_r == 4'h8) begin
					if (sh_r[7:1] == `OWN_ADDR7) begin
						st_r     <= S_AACK;
						sda_oe   <= 1'b1;
						rd_dir_r <= sh_r[0];
						rd_ptr_r <= 3'h0;
					end else begin
						st_r <= S_IDLE;
					end
				end
				S_AACK: if (scl_fall) begin
					bit_r  <= 4'h0;
					scl_oe <= 1'b1;
					str_r  <= `STRETCH_CYC;
					if (rd_dir_r) begin
						st_r <= S_RD;
						sh_r   <= out_byte;
						sda_oe <= ~out_byte[7];
					end else begin
						st_r   <= S_WR;
						sda_oe <= 1'b0;
					end
				end
				S_WR: if (scl_rise) begin
					sh_r  <= {sh_r[6:0], sda_q};
					bit_r <= bit_r + 4'h1;
				end else if (scl_fall && bit_r == 4'h8) begin
					st_r      <= S_AACK;
					sda_oe    <= 1'b1;
					cmd_valid <= 1'b1;
					cmd_byte  <= sh_r;
				end
				S_RD: if (scl_fall) begin
					if (bit_r == 4'h7) begin
						st_r   <= S_RACK;
						sda_oe <= 1'b0;
						if (pend_r) begin
							byte_out_p <= 1'b1;
							rd_ptr_r   <= rd_ptr_r + 3'h1;
						end
					end else begin
						sh_r   <= {sh_r[6:0], 1'b0};
						sda_oe <= ~sh_r[6];
						bit_r  <= bit_r + 4'h1;
					end
				end
				S_RACK: if (scl_rise) begin
					rd_dir_r <= 1'b1;
					// master high ack ends the read
					if (sda_q) begin
						st_r <= S_IDLE;
					end else begin
						bit_r <= 4'hF;
					end
				end else if (scl_fall && bit_r == 4'hF) begin
					st_r  <= S_RD;
					bit_r <= 4'h0;
					sh_r   <= out_byte;
					sda_oe <= ~out_byte[7];
				end
				default: st_r <= S_IDLE;
				endcase
			end
		end
	end

	// sdo: irq level in two-wire mode, shift data in spi mode
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sdo_out       <= 1'b0;
			sdo_oe        <= 1'b0;
			host_data_irq <= 1'b0;
			first_out_r   <= 1'b0;
		end else if (!spi_mode_r) begin
			sdo_oe        <= 1'b1;
			sdo_out       <= pend_r;
			host_data_irq <= 1'b0;
		end else begin
			sdo_oe  <= spi_sel;
			sdo_out <= sh_r[7];
			if (pkt_commit) begin
				first_out_r <= 1'b1;
			end else if (byte_out_p || sleep_enter) begin
				first_out_r <= 1'b0;
			end
			host_data_irq <= first_out_r & pend_r;
		end
	end
endmodule

// >>> rtl/touch_port_map.vh
// constants for the touch controller host serial port
`ifndef TOUCH_PORT_MAP_VH
`define TOUCH_PORT_MAP_VH
`define OWN_ADDR7          7'h4D
`define WR_ADDR_BYTE       8'h9A
`define RD_ADDR_BYTE       8'h9B
`define FILLER_BYTE        8'h4D
`define MSG_DEPTH          8
`define MSG_AW             3
`define STRETCH_CYC        4'h3
`endif

// >>> testbench/host_master.sv
// host model: two-wire bus master and spi master
module host_master (
	input  wire logic clk_sys,
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic sdo,
	output logic      scl_low,
	output logic      sda_low,
	output logic      ss_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_low = 0;
		sda_low = 0;
		ss_n = 1;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// bounded wait so a stuck clock cannot hang the run
	task automatic rel();
		int w = 0;
		scl_low = 0;
		hw(1);
		while (!scl && w < 400) begin
			hw(1);
			w++;
		end
	endtask
	task automatic pulse(output logic b);
		hw(6);
		rel();
		hw(7);
		b = sda;
		scl_low = 1;
		hw(2);
	endtask
	task automatic start();
		{scl_low, sda_low} = 2'h0;
		hw(8);
		sda_low = 1;
		hw(4);
		scl_low = 1;
		hw(2);
	endtask
	task automatic stop();
		sda_low = 1;
		hw(4);
		rel();
		hw(3);
		sda_low = 0;
		hw(8);
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			sda_low = !d[i];
			pulse(b);
		end
		sda_low = 0;
		pulse(b);
		ack = !b;
	endtask
	task automatic recv(input logic last, output logic [7:0] d);
		logic b;
		sda_low = 0;
		for (int i = 7; i >= 0; i--)
			pulse(d[i]);
		sda_low = !last;
		pulse(b);
		sda_low = 0;
	endtask
	// sck parked low before select, as spi mode idles
	task automatic sel(input logic on);
		scl_low = 1;
		hw(4);
		ss_n = !on;
		hw(8);
	endtask
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			sda_low = !d[i];
			hw(4);
			q[i] = sdo;
			scl_low = 0;
			hw(8);
			scl_low = 1;
			hw(4);
		end
	endtask
endmodule

// >>> testbench/touch_host_serial_port_bench.sv
// self-checking bench for the host serial port
module touch_host_serial_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys, rst_n, strap, fend = 0;
	logic       sleep_enter, pkt_wr, pkt_commit, stall_req;
	logic [7:0] pkt_data, d;
	logic [7:0] got[$];
	logic [7:0] frame[4] = '{8'h00, 8'h55, 8'h01, 8'h12};
	logic       a;
	int         fail_count = 0, samples_checked = 0;
	wire        scl_oe, sda_oe, sdo_out, sdo_oe, host_data_irq, cmd_valid;
	wire        cmd_frame_end, ss_n, scl_low, sda_low, scl_out, sda_out;
	wire [7:0]  cmd_byte;
	// open drain with pull-up: the device drives only its out level
	wire        scl = !scl_low && (scl_oe ? scl_out : 1'b1);
	wire        sda = !sda_low && (sda_oe ? sda_out : 1'b1);
	wire        sdo = sdo_oe ? sdo_out : 1'bz;
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (cmd_valid)
			got.push_back(cmd_byte);
		if (cmd_frame_end)
			fend <= 1;
	end
	touch_host_serial_port dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .interface_select_strap(strap),
		.scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe), .ss_n(ss_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
		.host_data_irq(host_data_irq), .sleep_enter(sleep_enter),
		.pkt_wr(pkt_wr), .pkt_data(pkt_data), .pkt_commit(pkt_commit),
		.stall_req(stall_req), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.cmd_frame_end(cmd_frame_end));
	host_master host (.clk_sys(clk_sys), .scl(scl), .sda(sda), .sdo(sdo),
		.scl_low(scl_low), .sda_low(sda_low), .ss_n(ss_n));
	task automatic check(input logic [7:0] seen, exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic boot(input logic s);
		rst_n = 0;
		strap = s;
		host.hw(4);
		rst_n = 1;
		host.hw(16);
	endtask
	task automatic push(input logic [7:0] v, input logic last);
		pkt_wr = 1;
		pkt_data = v;
		host.hw(1);
		pkt_wr = 0;
		pkt_commit = last;
		host.hw(1);
		pkt_commit = 0;
		host.hw(6);
	endtask
	task automatic t_write();
		stall_req = 1;
		fork
			begin
				host.hw(300);
				stall_req = 0;
			end
		join_none
		host.start();
		host.send(8'h9A, a);
		check(8'(a), 8'h01, "address ack");
		foreach (frame[i]) begin
			host.send(frame[i], a);
			check(8'(a), 8'h01, "data ack");
		end
		host.hw(5000);
		host.stop();
		check(8'(got.size()), 8'h04, "byte count");
		foreach (frame[i]) check(got[i], frame[i], "command");
		check(8'(fend), 8'h01, "frame end");
	endtask
	task automatic t_read();
		push(8'hC3, 0);
		push(8'h5A, 1);
		check(8'(sdo_out), 8'h01, "ready");
		host.start();
		host.send(8'h9B, a);
		check(8'(a), 8'h01, "read ack");
		host.recv(0, d);
		check(d, 8'hC3, "first byte");
		host.recv(1, d);
		check(d, 8'h5A, "last byte");
		host.stop();
		check(8'(sdo_out), 8'h00, "ready idle");
	endtask
	task automatic t_miss();
		got = {};
		host.start();
		host.send(8'h9E, a);
		check(8'(a), 8'h00, "foreign ack");
		host.send(8'h55, a);
		check(8'(a), 8'h00, "ignored ack");
		host.stop();
		check(8'(got.size()), 8'h00, "ignored");
	endtask
	task automatic t_sleep();
		push(8'h77, 1);
		sleep_enter = 1;
		host.hw(1);
		sleep_enter = 0;
		host.hw(6);
		check(8'(sdo_out), 8'h00, "sleep ready");
		host.start();
		host.send(8'h9B, a);
		host.recv(1, d);
		host.stop();
		check(d, 8'h4D, "filler");
	endtask
	task automatic t_spi();
		boot(1);
		host.sel(0);
		check(8'(sdo_oe), 8'h00, "sdo off");
		push(8'hE1, 0);
		push(8'h0F, 1);
		check(8'(host_data_irq), 8'h01, "irq up");
		host.sel(1);
		got = {};
		host.xfer(8'hA5, d);
		check(d, 8'hE1, "spi first");
		host.hw(6);
		check(8'(host_data_irq), 8'h00, "irq down");
		host.xfer(8'h3C, d);
		check(d, 8'h0F, "spi second");
		host.xfer(8'h00, d);
		check(d, 8'h4D, "spi filler");
		host.sel(0);
		check(8'(sdo_oe), 8'h00, "sdo freed");
		check(got[0], 8'hA5, "spi in");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		{clk_sys, sleep_enter, pkt_wr, pkt_commit, stall_req} = 5'h00;
		pkt_data = 8'h00;
		boot(0);
		t_write();
		t_read();
		t_miss();
		t_sleep();
		t_spi();
		results();
	end
	// about six times the expected run length
	initial begin
		#500us;
		fail_count++;
		results();
	end
endmodule

// >>> testbench/touch_port_chk.sv
// pin-level assertions for the host serial port
module touch_port_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic interface_select_strap,
	input wire logic scl_in,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic ss_n,
	input wire logic sdo_out,
	input wire logic sdo_oe,
	input wire logic host_data_irq,
	input wire logic sleep_enter,
	input wire logic pkt_commit,
	input wire logic stall_req,
	input wire logic cmd_valid
);
	logic [3:0] up_r;
	// strap is caught only after reset, so mode checks wait
	wire spi = interface_select_strap && up_r == 4'hF;
	wire tw = !interface_select_strap && up_r == 4'hF;
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			up_r <= 4'h0;
		else if (up_r != 4'hF)
			up_r <= up_r + 4'h1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_ack_up;
		$rose(sda_oe) && !scl_in;
	endsequence
	sequence s_free_hold;
		$rose(scl_oe) && !stall_req;
	endsequence
	chk_sda_moves: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("sda moved, scl high");
	chk_ack_stands: assert property (s_ack_up |=> sda_oe until scl_in)
		else $error("sda let go early");
	chk_stretch_end: assert property (s_free_hold |-> ##[1:8] !scl_oe)
		else $error("scl held too long");
	chk_stall_keep: assert property (scl_oe && stall_req |=> scl_oe)
		else $error("scl freed in stall");
	chk_write_ack: assert property (cmd_valid && tw |-> $rose(sda_oe))
		else $error("byte not acked");
	chk_ready_flag: assert property (pkt_commit && tw |-> ##[1:4] sdo_out)
		else $error("no ready on sdo");
	chk_sleep_drop: assert property (sleep_enter |->
		##[1:4] !host_data_irq && (spi || !sdo_out))
		else $error("data kept in sleep");
	chk_ss_float: assert property ((spi && ss_n) [*6] |-> !sdo_oe)
		else $error("sdo driven, deselected");
endmodule
bind touch_host_serial_port touch_port_chk chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl_in), .scl_oe(scl_oe),
	.interface_select_strap(interface_select_strap), .sda_oe(sda_oe),
	.ss_n(ss_n), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .stall_req(stall_req),
	.host_data_irq(host_data_irq), .sleep_enter(sleep_enter),
	.pkt_commit(pkt_commit), .cmd_valid(cmd_valid));
